// ---- common/cscr_params.svh ----
// Constants for the card configuration and address register block
//
// Functional notes
// - Read and write block length codes both read 9, i.e. 512-byte blocks.
// - Partial-block flags read 0; only whole 512-byte blocks may be accessed.
// - Misalignment flags read 0; accesses crossing a block boundary are refused.
// - Driver-stage flag reads 1 when the driver register exists, else 0.
// - Device size is 22 bits; capacity equals (value plus one) times 512K bytes.
// - Upper 6 bits of the device size are held at zero.
// - Single-unit erase flag reads 1; erases of whole 512-byte units are accepted.
// - Sector size reads 7Fh (64 KBytes) and does not govern erase.
// - Protect group size reads 00h and protect group enable reads 0.
// - File format group flag and file format field read 0.
// - Copy flag: 0 original, 1 copied; once set it never clears.
// - Permanent protect bit defaults 0; once set, writes and erases are refused forever.
// - Temporary protect bit is settable and clearable, defaults 0, blocks writes and erases.
// - Writable 16-bit relative address register used for addressed traffic.
// - Relative address resets to 0x0000; selecting 0x0000 returns cards to stand-by.
// - Structure version field reads 1.
// - Transfer speed reads 032h in default timing, 05Ah in high-speed timing.
`ifndef CSCR_PARAMS_SVH
`define CSCR_PARAMS_SVH

// Register byte offsets on the bus
`define CSCR_OFS_CFG3 32'h0000_0000
`define CSCR_OFS_CFG2 32'h0000_0004
`define CSCR_OFS_CFG1 32'h0000_0008
`define CSCR_OFS_CFG0 32'h0000_000C
`define CSCR_OFS_ADDR 32'h0000_0010
`define CSCR_OFS_CTRL 32'h0000_0014
`define CSCR_OFS_STAT 32'h0000_0018

// Fixed field values of the configuration image
`define CSCR_STRUCT_VER 2'h1
`define CSCR_ACCESS_TIME 8'h0E
`define CSCR_ACCESS_CLKS 8'h00
`define CSCR_SPEED_DEFAULT 8'h32
`define CSCR_SPEED_HIGH 8'h5A
`define CSCR_CMD_CLASSES 12'h5B5
`define CSCR_BLOCK_LEN_CODE 4'h9
`define CSCR_SECTOR_SIZE 7'h7F
`define CSCR_GROUP_SIZE 7'h00
`define CSCR_RW_FACTOR 3'h2
`define CSCR_SIZE_UPPER 6'h00

// Field positions within the low word of the image
`define CSCR_BIT_COPY 14
`define CSCR_BIT_PERM 13
`define CSCR_BIT_TEMP 12
`define CSCR_CRC_LSB 1

// Reset values and sizes
`define CSCR_ADDR_RESET 16'h0000
`define CSCR_CAP_UNITS_DEF 16'h0000
`define CSCR_DSR_DEF 1'b0
`define CSCR_BLOCK_MASK 16'h01FF
`define CSCR_LINK_LAST_BIT 7'h7F
`define CSCR_HSIZE_WORD 3'h2

`endif

// ---- common/cscr_pkg.sv ----
// Types shared by the configuration register block
package cscr_pkg;
   typedef logic [127:0] cscr_cfg_type;
   typedef logic [119:0] cscr_body_type;
   typedef enum logic [1:0] {
      ACC_READ = 2'b00,
      ACC_WRITE = 2'b01,
      ACC_ERASE = 2'b10
   } cscr_acc_kind_type;
   typedef enum logic [0:0] {
      LINK_IDLE = 1'b0,
      LINK_SEND = 1'b1
   } cscr_link_state_type;
endpackage

// ---- hdl/cscr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cscr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   // First stage feeds only the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= din;
         stable_q <= meta_q;
      end
   end

   assign dout = stable_q;
endmodule

// ---- hdl/cscr_crc7.sv ----
// Seven-bit checksum over the upper 120 bits of the configuration image
`timescale 1ns/1ps
module cscr_crc7 (
   input cscr_pkg::cscr_body_type body,
   output logic [6:0] crc
);
   import cscr_pkg::*;

   // Polynomial x^7 + x^3 + 1, most significant bit first
   function automatic logic [6:0] crcOf(input cscr_body_type b);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 119; i >= 0; i--) begin
         fb = c[6] ^ b[i];
         c = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ 7'h09;
         end
      end
      return c;
   endfunction

   assign crc = crcOf(body);
endmodule

// ---- hdl/cscr_regs.sv ----
// Card configuration image, relative address register, access guard and serial readout
`timescale 1ns/1ps
`include "cscr_params.svh"
module cscr_regs #(
   parameter logic [15:0] CAP_UNITS = `CSCR_CAP_UNITS_DEF,
   parameter logic DRIVER_STAGE = `CSCR_DSR_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic selReq,
   input wire logic [15:0] selAddr,
   input wire logic timingReset,
   input wire logic accReq,
   input wire cscr_pkg::cscr_acc_kind_type accKind,
   input wire logic [8:0] accOffset,
   input wire logic [15:0] accLen,
   output logic accGrant,
   output logic accRefuse,
   output logic cardSelected,
   output logic [15:0] relativeCardAddress,
   input wire logic linkClk,
   input wire logic linkSendReq,
   output logic linkDat,
   output logic linkDatOe_n
);
   import cscr_pkg::*;

   // Bus data phase bookkeeping
   logic wrPend_q;
   logic [31:0] wrAddr_q;
   logic [31:0] hrdata_q;

   // Programmable fields
   logic copyFlag_q;
   logic permProtect_q;
   logic tempProtect_q;
   logic [6:0] crcWritten_q;
   logic crcOverride_q;
   logic [15:0] rca_q;
   logic highSpeed_q;

   // Card-side results
   logic selected_q;
   logic accGrant_q;
   logic accRefuse_q;
   logic lastRefused_q;

   // Link side
   logic [1:0] linkSync;
   logic linkClkD_q;
   logic sendReqD_q;
   cscr_link_state_type linkState_q;
   cscr_cfg_type shift_q;
   logic [6:0] bitCnt_q;
   logic linkDat_q;
   logic linkDatOe_n_q;

   logic addrPhase;
   logic [6:0] crcCalc;
   logic [6:0] crcShown;
   cscr_body_type body;
   cscr_cfg_type image;
   logic protectedNow;
   logic linkFall;
   logic sendRise;

   // Whole-block length test shared by reads, writes and erases
   function automatic logic wholeBlocks(input logic [15:0] len);
      return (len != 16'h0000) && ((len & `CSCR_BLOCK_MASK) == 16'h0000);
   endfunction

   // Upper 120 bits of the image; constant fields are fixed here
   function automatic cscr_body_type buildBody(input logic hs, input logic cp,
                                               input logic pp, input logic tp);
      cscr_body_type b;
      b = {
         `CSCR_STRUCT_VER,
         6'h00,
         `CSCR_ACCESS_TIME,
         `CSCR_ACCESS_CLKS,
         hs ? `CSCR_SPEED_HIGH : `CSCR_SPEED_DEFAULT,
         `CSCR_CMD_CLASSES,
         `CSCR_BLOCK_LEN_CODE,
         1'b0,
         1'b0,
         1'b0,
         DRIVER_STAGE,
         6'h00,
         `CSCR_SIZE_UPPER,
         CAP_UNITS,
         1'b0,
         1'b1,
         `CSCR_SECTOR_SIZE,
         `CSCR_GROUP_SIZE,
         1'b0,
         2'b00,
         `CSCR_RW_FACTOR,
         `CSCR_BLOCK_LEN_CODE,
         1'b0,
         5'h00,
         1'b0,
         cp,
         pp,
         tp,
         2'b00,
         2'b00                                              // Reserved pair just above the checksum
      };
      return b;
   endfunction

   // Image assembly and its checksum
   assign body = buildBody(highSpeed_q, copyFlag_q, permProtect_q, tempProtect_q);

   cscr_crc7 crcUnit (
      .body(body),
      .crc(crcCalc)
   );

   // Until software loads a checksum the computed one is shown, matching the contents
   assign crcShown = crcOverride_q ? crcWritten_q : crcCalc;
   assign image = {body, crcShown, 1'b1};
   assign protectedNow = permProtect_q | tempProtect_q;

   // Address phase seen by this slave
   assign addrPhase = hsel & htrans[1] & hready;

   // Capture write address for the following data phase; only whole words are taken
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 32'h0000_0000;
      end else if (hready) begin
         wrPend_q <= addrPhase & hwrite & (hsize == `CSCR_HSIZE_WORD);
         wrAddr_q <= haddr;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addrPhase & ~hwrite) begin
         if (haddr == `CSCR_OFS_CFG3) begin
            hrdata_q <= image[127:96];
         end else if (haddr == `CSCR_OFS_CFG2) begin
            hrdata_q <= image[95:64];
         end else if (haddr == `CSCR_OFS_CFG1) begin
            hrdata_q <= image[63:32];
         end else if (haddr == `CSCR_OFS_CFG0) begin
            hrdata_q <= image[31:0];
         end else if (haddr == `CSCR_OFS_ADDR) begin
            hrdata_q <= {16'h0000, rca_q};
         end else if (haddr == `CSCR_OFS_CTRL) begin
            hrdata_q <= {31'h0000_0000, highSpeed_q};
         end else if (haddr == `CSCR_OFS_STAT) begin
            hrdata_q <= {27'h000_0000, crcOverride_q, lastRefused_q, protectedNow,
                         linkState_q == LINK_SEND, selected_q};
         end else begin
            hrdata_q <= 32'h0000_0000;
         end
      end
   end

   // Copy and permanent protection only ever set; temporary follows the write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         copyFlag_q <= 1'b0;
         permProtect_q <= 1'b0;
         tempProtect_q <= 1'b0;
      end else if (wrPend_q && (wrAddr_q == `CSCR_OFS_CFG0)) begin
         copyFlag_q <= copyFlag_q | hwdata[`CSCR_BIT_COPY];
         permProtect_q <= permProtect_q | hwdata[`CSCR_BIT_PERM];
         tempProtect_q <= hwdata[`CSCR_BIT_TEMP];
      end
   end

   // Checksum written by software replaces the computed one from then on
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         crcWritten_q <= 7'h00;
         crcOverride_q <= 1'b0;
      end else if (wrPend_q && (wrAddr_q == `CSCR_OFS_CFG0)) begin
         crcWritten_q <= hwdata[`CSCR_CRC_LSB+6:`CSCR_CRC_LSB];
         crcOverride_q <= 1'b1;
      end
   end

   // Relative address register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rca_q <= `CSCR_ADDR_RESET;
      end else if (wrPend_q && (wrAddr_q == `CSCR_OFS_ADDR)) begin
         rca_q <= hwdata[15:0];
      end
   end

   // Timing mode; a return to default timing wins over a software set
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         highSpeed_q <= 1'b0;
      end else if (timingReset) begin
         highSpeed_q <= 1'b0;
      end else if (wrPend_q && (wrAddr_q == `CSCR_OFS_CTRL)) begin
         highSpeed_q <= hwdata[0];
      end
   end

   // Selection: the reserved zero address deselects every card
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         selected_q <= 1'b0;
      end else if (selReq) begin
         if (selAddr == 16'h0000) begin
            selected_q <= 1'b0;
         end else begin
            selected_q <= (selAddr == rca_q);
         end
      end
   end

   // Access guard; one-cycle answer a clock after the request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         accGrant_q <= 1'b0;
         accRefuse_q <= 1'b0;
         lastRefused_q <= 1'b0;
      end else if (accReq) begin
         if (accOffset != 9'h000) begin
            accGrant_q <= 1'b0;
            accRefuse_q <= 1'b1;
            lastRefused_q <= 1'b1;
         end else if (!wholeBlocks(accLen)) begin
            accGrant_q <= 1'b0;
            accRefuse_q <= 1'b1;
            lastRefused_q <= 1'b1;
         end else if ((accKind != ACC_READ) && protectedNow) begin
            accGrant_q <= 1'b0;
            accRefuse_q <= 1'b1;
            lastRefused_q <= 1'b1;
         end else if ((accKind == ACC_READ) || (accKind == ACC_WRITE) || (accKind == ACC_ERASE)) begin
            accGrant_q <= 1'b1;
            accRefuse_q <= 1'b0;
            lastRefused_q <= 1'b0;
         end else begin
            accGrant_q <= 1'b0;
            accRefuse_q <= 1'b1;
            lastRefused_q <= 1'b1;
         end
      end else begin
         accGrant_q <= 1'b0;
         accRefuse_q <= 1'b0;
      end
   end

   // Link pins cross into the bus clock before any use
   cscr_sync #(
      .WIDTH(2)
   ) linkIn (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({linkSendReq, linkClk}),
      .dout(linkSync)
   );

   // Edge finders on the synchronised link signals
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         linkClkD_q <= 1'b0;
         sendReqD_q <= 1'b0;
      end else begin
         linkClkD_q <= linkSync[0];
         sendReqD_q <= linkSync[1];
      end
   end

   assign linkFall = linkClkD_q & ~linkSync[0];
   assign sendRise = linkSync[1] & ~sendReqD_q;

   // Serial readout of the image, most significant bit first, advanced on link clock falls.
   // Dropping the request ends the frame, so a stopped link clock never hangs the shifter.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         linkState_q <= LINK_IDLE;
         shift_q <= '0;
         bitCnt_q <= 7'h00;
         linkDat_q <= 1'b1;
         linkDatOe_n_q <= 1'b1;
      end else begin
         case (linkState_q)
            LINK_IDLE: begin
               if (sendRise) begin
                  linkState_q <= LINK_SEND;
                  shift_q <= image;
                  bitCnt_q <= 7'h00;
                  linkDat_q <= image[127];
                  linkDatOe_n_q <= 1'b0;
               end
            end
            LINK_SEND: begin
               if (!linkSync[1]) begin
                  linkState_q <= LINK_IDLE;
                  linkDat_q <= 1'b1;
                  linkDatOe_n_q <= 1'b1;
               end else if (linkFall) begin
                  if (bitCnt_q == `CSCR_LINK_LAST_BIT) begin
                     linkState_q <= LINK_IDLE;
                     linkDat_q <= 1'b1;
                     linkDatOe_n_q <= 1'b1;
                  end else begin
                     shift_q <= {shift_q[126:0], 1'b0};
                     bitCnt_q <= bitCnt_q + 7'h01;
                     linkDat_q <= shift_q[126];
                  end
               end
            end
            default: begin
               linkState_q <= LINK_IDLE;
               linkDatOe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // Outputs, each straight from a flop
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign accGrant = accGrant_q;
   assign accRefuse = accRefuse_q;
   assign cardSelected = selected_q;
   assign relativeCardAddress = rca_q;
   assign linkDat = linkDat_q;
   assign linkDatOe_n = linkDatOe_n_q;
endmodule

// ---- tb/cscr_regs_asserts.sv ----
// Port-level checks for the card configuration register block
`timescale 1ns/1ps
module cscr_regs_asserts (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic selReq,
   input wire logic [15:0] selAddr,
   input wire logic accReq,
   input wire cscr_pkg::cscr_acc_kind_type accKind,
   input wire logic [8:0] accOffset,
   input wire logic [15:0] accLen,
   input wire logic accGrant,
   input wire logic accRefuse,
   input wire logic cardSelected,
   input wire logic [15:0] relativeCardAddress,
   input wire logic linkSendReq,
   input wire logic linkDat,
   input wire logic linkDatOe_n
);
   import cscr_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Request rising while idle and held past the pin synchroniser
   sequence frameAsked;
      $rose(linkSendReq) ##0 linkDatOe_n ##1 linkSendReq [*6];
   endsequence
   // Access answers come one cycle after the request
   offset_refuse_a: assert property (accReq && accOffset != 9'h000 |=> accRefuse && !accGrant)
      else $error("misaligned access not refused");
   length_refuse_a: assert property (accReq && (accLen[8:0] != 9'h000 || accLen == 16'h0000) |=> accRefuse)
      else $error("partial block access not refused");
   grant_block_a: assert property (accReq && accKind == ACC_READ && accOffset == 9'h000 && accLen == 16'h0200 |=> accGrant)
      else $error("whole block read not granted");
   one_answer_a: assert property (accReq |=> accGrant != accRefuse)
      else $error("access answer missing or doubled");
   no_request_a: assert property (!accReq |=> !accGrant && !accRefuse)
      else $error("access answer without request");
   // Selection follows the relative address
   sel_zero_a: assert property (selReq && selAddr == 16'h0000 |=> !cardSelected)
      else $error("reserved address selected the card");
   sel_match_a: assert property (selReq && selAddr != 16'h0000 && selAddr == relativeCardAddress |=> cardSelected)
      else $error("own address did not select the card");
   sel_hold_a: assert property (!selReq |=> $stable(cardSelected))
      else $error("selection changed without request");
   // First bit out is the top of the version field, which reads 01
   frame_start_a: assert property (frameAsked |-> !linkDatOe_n && !linkDat)
      else $error("readout did not start with version bit");
endmodule

bind cscr_regs cscr_regs_asserts u_chk (.mclk, .rst_n, .selReq, .selAddr, .accReq, .accKind, .accOffset,
   .accLen, .accGrant, .accRefuse, .cardSelected, .relativeCardAddress, .linkSendReq, .linkDat, .linkDatOe_n);

// ---- tb/cscr_link_host.sv ----
// Host-side model of the serial configuration readout link
`timescale 1ns/1ps
module cscr_link_host (
   output logic linkClk,
   output logic linkSendReq,
   input wire logic linkDat,
   input wire logic linkDatOe_n
);
   // Link clock stands low between frames
   initial begin
      linkClk = 1'b0;
      linkSendReq = 1'b0;
   end
   // One frame of 128 bits at 320 ns; sampled just before the fall that shifts the next bit
   task frame(output logic [127:0] v);
      linkSendReq = 1'b1;
      #400;
      for (int i = 127; i >= 0; i--) begin
         #160;
         linkClk = 1'b1;
         #160;
         v[i] = linkDatOe_n ? 1'bx : linkDat; // Released line is never trusted
         linkClk = 1'b0;
      end
      #400;
      linkSendReq = 1'b0;
      #400;
   endtask
endmodule

// ---- tb/cscr_regs_tb.sv ----
// Self-checking bench for the card configuration register block
`timescale 1ns/1ps
`include "cscr_params.svh"
module cscr_regs_tb;
   import cscr_pkg::*;
   logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, selReq = 0, timingReset = 0, accReq = 0, rdPh = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] selAddr = 0, accLen = 0, relative_card_address, relativeCardAddress;
   logic [8:0] accOffset = 0;
   cscr_acc_kind_type accKind = ACC_READ;
   logic hreadyout, hresp, accGrant, accRefuse, cardSelected, linkClk, linkSendReq, linkDat, linkDatOe_n;
   logic [63:0] rdQ[$];
   logic [1:0] accQ[$];
   logic [63:0] rq;
   logic [127:0] img;
   // Expected image words, top word first, for size ABCD and driver stage present
   logic [31:0] cfg[4] = '{32'h400E_0032, 32'h5B59_1000, 32'hABCD_7F80, 32'h0A40_0001};
   int num_errors = 0, check_count = 0, n, seed = 32'h842F1ADF;

   always #20 mclk = ~mclk;

   cscr_regs #(.CAP_UNITS(16'hABCD), .DRIVER_STAGE(1'b1)) dut (.mclk, .rst_n, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .selReq, .selAddr,
      .timingReset, .accReq, .accKind, .accOffset, .accLen, .accGrant, .accRefuse, .cardSelected,
      .relativeCardAddress, .linkClk, .linkSendReq, .linkDat, .linkDatOe_n);

   cscr_link_host host (.linkClk, .linkSendReq, .linkDat, .linkDatOe_n);

   // Masked comparison; unknown bits inside the mask never match
   task chk(input string what, input logic [127:0] e, s, m);
      check_count++;
      if ((s & m) !== (e & m)) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, e & m, s & m);
      end
   endtask

   // Seven-bit checksum x^7 + x^3 + 1 over image bits 127:8, top bit first
   function automatic logic [6:0] crc7(input logic [119:0] b);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 119; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ (((c[6] ^ b[i]) == 1'b1) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction

   task stop_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Bounded wait for hready at a rising edge
   task waitRdy;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         stop_test;
      end
   endtask

   // Single word transfer; reads note the expected data and mask
   task ahb(input logic w, input logic [31:0] a, d, e, m);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      if (!w) rdQ.push_back({e, m});
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
   endtask

   task acc(input cscr_acc_kind_type k, input logic [8:0] o, input logic [15:0] l, input logic g);
      accReq <= 1'b1;
      accKind <= k;
      accOffset <= o;
      accLen <= l;
      accQ.push_back({g, !g});
      @(posedge mclk);
   endtask

   // Write, erase and read of one whole block, back to back
   task prot(input logic g);
      acc(ACC_WRITE, 9'h000, 16'h0200, g);
      acc(ACC_ERASE, 9'h000, 16'h0200, g);
      acc(ACC_READ, 9'h000, 16'h0200, 1'b1);
      accReq <= 1'b0;
      @(posedge mclk);
   endtask

   task sel(input logic [15:0] a, input logic e);
      selReq <= 1'b1;
      selAddr <= a;
      @(posedge mclk);
      selReq <= 1'b0;
      @(posedge mclk);
      chk("cardSelected", e, cardSelected, 1);
   endtask

   // Takes the oldest note whenever read data or an access answer appears
   always @(posedge mclk) begin
      if (rdPh) begin
         rq = rdQ.pop_front();
         chk("hrdata", rq[63:32], hrdata, rq[31:0]);
         chk("hresp", 0, hresp, 1);
      end
      rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
      if (accGrant || accRefuse) chk("access answer", accQ.pop_front(), {accGrant, accRefuse}, 2'h3);
   end

   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      host.frame(img);
      chk("image", {cfg[0], cfg[1], cfg[2], cfg[3]}, img, {{96{1'b1}}, 32'hFFFF_BF01});
      chk("checksum", crc7({cfg[0], cfg[1], cfg[2], cfg[3][31:8]}), img[7:1], 7'h7F);
      chk("device size", 22'h00_ABCD, img[69:48], 22'h3F_FFFF);
      chk("sector size", 7'h7F, img[45:39], 7'h7F);
      chk("read_to_write_factor", 3'h2, img[28:26], 3'h7);
      chk("file format", 3'h0, {img[15], img[11:10]}, 3'h7);
      @(posedge mclk);
      for (int i = 0; i < 4; i++) ahb(0, 4 * i, 0, cfg[i], (i == 3) ? 32'hFFFF_BF01 : 32'hFFFF_FFFF);
      ahb(0, `CSCR_OFS_ADDR, 0, 0, 32'hFFFF_FFFF);
      ahb(0, 32'h0000_0040, 0, 0, 32'hFFFF_FFFF);
      // The top image word is read-only; speed tracks the timing mode
      ahb(1, `CSCR_OFS_CFG3, $random(seed), 0, 0);
      ahb(0, `CSCR_OFS_CFG3, 0, cfg[0], 32'hFFFF_FFFF);
      ahb(1, `CSCR_OFS_CTRL, 32'h0000_0001, 0, 0);
      ahb(0, `CSCR_OFS_CFG3, 0, 32'h400E_005A, 32'hFFFF_FFFF);
      timingReset <= 1'b1;
      @(posedge mclk);
      timingReset <= 1'b0;
      @(posedge mclk);
      ahb(0, `CSCR_OFS_CFG3, 0, cfg[0], 32'hFFFF_FFFF);
      relative_card_address = 16'($random(seed)) | 16'h0001;
      ahb(1, `CSCR_OFS_ADDR, {16'h0000, relative_card_address}, 0, 0);
      ahb(0, `CSCR_OFS_ADDR, 0, {16'h0000, relative_card_address}, 32'hFFFF_FFFF);
      chk("relativeCardAddress", relative_card_address, relativeCardAddress, 16'hFFFF);
      sel(relative_card_address, 1);
      sel(relative_card_address ^ 16'h8000, 0);
      sel(relative_card_address, 1);
      sel(16'h0000, 0);
      // Whole blocks only, at offset zero
      acc(ACC_READ, 9'h000, 16'h0200, 1);
      acc(ACC_WRITE, 9'h000, 16'h0400, 1);
      acc(ACC_ERASE, 9'h000, 16'h0200, 1);
      acc(ACC_WRITE, 9'h001, 16'h0200, 0);
      acc(ACC_READ, 9'h100, 16'h0200, 0);
      acc(ACC_READ, 9'h000, 16'h0100, 0);
      acc(ACC_WRITE, 9'h000, 16'h0000, 0);
      acc(cscr_acc_kind_type'(2'h3), 9'h000, 16'h0200, 0);
      accReq <= 1'b0;
      @(posedge mclk);
      // Temporary protect sets and clears; checksum bits show as written
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_10AA, 0, 0);
      ahb(0, `CSCR_OFS_CFG0, 0, cfg[3] | 32'h0000_10AB, 32'hFFFF_BFFF);
      prot(0);
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_0000, 0, 0);
      prot(1);
      // Copy and permanent protect never clear
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_4000, 0, 0);
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_0000, 0, 0);
      ahb(0, `CSCR_OFS_CFG0, 0, cfg[3] | 32'h0000_4000, 32'hFFFF_FFFF);
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_2000, 0, 0);
      ahb(1, `CSCR_OFS_CFG0, 32'h0000_0000, 0, 0);
      ahb(0, `CSCR_OFS_CFG0, 0, cfg[3] | 32'h0000_6000, 32'hFFFF_FFFF);
      prot(0);
      ahb(0, `CSCR_OFS_STAT, 0, 32'h0000_0014, 32'hFFFF_FFFF);
      host.frame(img);
      chk("image", {cfg[0], cfg[1], cfg[2], cfg[3] | 32'h0000_6000}, img, '1);
      repeat (2) @(posedge mclk);
      chk("notes left", 0, rdQ.size() + accQ.size(), '1);
      stop_test;
   end
endmodule
